// File: spch_top.sv
// Standby and standby-immediate command handler with APB registers
//
// The placing of the registers and the APB register port were chosen for this implementation.
`include "spch_map.svh"
`timescale 1ns/1ns
`default_nettype none

module spch_top #(
    parameter int SEC_CYCLES = `SPCH_CLK_HZ * `SPCH_TICK_S
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Drive mechanics, asynchronous levels
    input  wire logic        cache_clean,
    input  wire logic        spun_down,
    input  wire logic        at_speed,
    // Drive requests
    output logic             flush_req,
    output logic             spin_down_req,
    output logic             spin_up_req,
    output logic             media_ready,
    // Interrupt
    output logic             irq
);

    if (SEC_CYCLES < 2) begin : g_bad_sec
        $error("SEC_CYCLES must be at least 2");
    end

    //------------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------------
    spch_pkg::spch_drive_s sync1;
    spch_pkg::spch_drive_s drv;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            drv   <= '0;
        end else begin
            sync1 <= '{cache_clean, spun_down, at_speed};
            drv   <= sync1;
        end
    end

    //------------------------------------------------------------------
    // Timeout decode
    //------------------------------------------------------------------
    // RULE6: zero gives no interval
    function automatic logic [15:0] timeout_s(input logic [7:0] c);
        logic [15:0] v;
        v = 16'h0000;
        if (c == 8'h00) begin
            v = 16'h0000;
        // RULE7: count times five
        end else if (c <= 8'hF0) begin
            v = 16'(c) * `SPCH_STEP_S;
        // RULE8: half-hour steps
        end else if (c <= 8'hFB) begin
            v = 16'(c - 8'hF0) * `SPCH_HALFHOUR_S;
        // RULE9: special codes
        end else if (c == 8'hFC) begin
            v = `SPCH_C252_S;
        end else if (c == 8'hFD) begin
            v = `SPCH_C253_S;
        end else if (c == 8'hFF) begin
            v = `SPCH_C255_S;
        end
        // Reserved 254 leaves the timer disabled
        return v;
    endfunction

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    spch_pkg::spch_state_e state;
    spch_pkg::spch_state_e next_state;
    spch_pkg::spch_status_s ata_status;
    spch_pkg::spch_status_s next_ata_status;
    logic [7:0]  ata_error;
    logic [7:0]  next_ata_error;
    logic [7:0]  last_cmd;
    logic [7:0]  next_last_cmd;
    logic [7:0]  tmo_count;
    logic [7:0]  next_tmo_count;
    logic [15:0] remain;
    logic [15:0] next_remain;
    logic [31:0] presc;
    logic [31:0] next_presc;
    logic        cmd_busy;
    logic        next_cmd_busy;
    logic        auto_run;
    logic        next_auto_run;
    logic        media_wait;
    logic        next_media_wait;
    logic [2:0]  int_stat;
    logic [2:0]  next_int_stat;
    logic [2:0]  int_mask;
    logic [2:0]  next_int_mask;
    logic [31:0] next_prdata;

    logic        wr_acc;
    logic        rd_setup;
    logic        mapped;
    logic        cmd_wr;
    logic        acc_wr;
    logic [7:0]  opc;
    logic [7:0]  cnt;
    logic        is_timed;
    logic        is_immed;
    logic        accepted;
    logic        tick;
    logic [2:0]  ev;

    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped   = (paddr == `SPCH_OFF_CMD)     ||
                      (paddr == `SPCH_OFF_STATUS)  ||
                      (paddr == `SPCH_OFF_TIMER)   ||
                      (paddr == `SPCH_OFF_ACCESS)  ||
                      (paddr == `SPCH_OFF_INTSTAT) ||
                      (paddr == `SPCH_OFF_INTMASK);
    assign cmd_wr   = wr_acc & (paddr == `SPCH_OFF_CMD);
    assign acc_wr   = wr_acc & (paddr == `SPCH_OFF_ACCESS);
    assign opc      = pwdata[7:0];
    assign cnt      = pwdata[15:8];
    assign is_timed = (opc == `SPCH_OP_STBY_A) | (opc == `SPCH_OP_STBY_B);
    assign is_immed = (opc == `SPCH_OP_STBYI_A) |
                      (opc == `SPCH_OP_STBYI_B);
    // Commands during a running one are dropped, not queued
    assign accepted = cmd_wr & ~cmd_busy;
    assign tick     = (presc == 32'(SEC_CYCLES - 1));

    // RULE2: bus never stalls, even while spinning down
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;

    assign flush_req     = (state == spch_pkg::ST_FLUSH);
    assign spin_down_req = (state == spch_pkg::ST_SPINDOWN);
    assign spin_up_req   = (state == spch_pkg::ST_SPINUP);
    assign media_ready   = (state == spch_pkg::ST_IDLE) & drv.at_speed;
    assign irq           = |(int_stat & int_mask);

    //------------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------------
    always_comb begin
        next_state      = state;
        next_ata_status = ata_status;
        next_ata_error  = ata_error;
        next_last_cmd   = last_cmd;
        next_tmo_count  = tmo_count;
        next_remain     = remain;
        next_presc      = presc;
        next_cmd_busy   = cmd_busy;
        next_auto_run   = auto_run;
        next_media_wait = media_wait;
        next_int_mask   = int_mask;
        next_prdata     = prdata;
        ev              = 3'h0;

        if (accepted) begin
            next_last_cmd = opc;
            if (is_timed | is_immed) begin
                // RULE1: load setting from the count field
                if (is_timed) begin
                    next_tmo_count = cnt;
                end
                // RULE13: immediate form leaves tmo_count alone
                // RULE12: standby entry starts at once
                next_state      = spch_pkg::ST_FLUSH;
                next_cmd_busy   = 1'b1;
                next_auto_run   = 1'b0;
                next_ata_status = '{bsy: 1'b1, default: 1'b0};
                next_ata_error  = 8'h00;
            end else begin
                // Unsupported opcode completes with abort
                next_ata_status = '{rdy: 1'b1, dsc: 1'b1, err: 1'b1,
                                    default: 1'b0};
                next_ata_error  = 8'h04;
                ev[`SPCH_IRQ_DONE] = 1'b1;
            end
        end

        case (state)
            spch_pkg::ST_IDLE: begin
                // RULE5: count only while idle
                if (tmo_count != 8'h00 && remain != 16'h0000) begin
                    next_presc = tick ? 32'h0 : presc + 32'h1;
                    // RULE10: expiry enters standby on its own
                    if (tick && remain == 16'h0001) begin
                        next_state    = spch_pkg::ST_FLUSH;
                        next_auto_run = 1'b1;
                        next_remain   = 16'h0000;
                    end else if (tick) begin
                        next_remain = remain - 16'h0001;
                    end
                end
            end
            // RULE2: cached writes complete before spin-down
            spch_pkg::ST_FLUSH: begin
                if (drv.cache_clean) begin
                    // RULE3: no spin-down when already stopped
                    next_state = drv.spun_down ? spch_pkg::ST_STANDBY
                                               : spch_pkg::ST_SPINDOWN;
                end
            end
            spch_pkg::ST_SPINDOWN: begin
                if (drv.spun_down) begin
                    next_state = spch_pkg::ST_STANDBY;
                end
            end
            spch_pkg::ST_STANDBY: begin
                if (cmd_busy) begin
                    // RULE14: only abort may show; fixed status
                    next_cmd_busy   = 1'b0;
                    next_ata_status = '{rdy: 1'b1, dsc: 1'b1,
                                        default: 1'b0};
                    next_ata_error  = 8'h00;
                    ev[`SPCH_IRQ_DONE] = 1'b1;
                end
                if (auto_run) begin
                    next_auto_run = 1'b0;
                    ev[`SPCH_IRQ_AUTO] = 1'b1;
                end
                // RULE4: media access waits for spindle speed
                if (media_wait || (acc_wr && pwdata[0])) begin
                    next_state = spch_pkg::ST_SPINUP;
                end
            end
            spch_pkg::ST_SPINUP: begin
                // A command taken now must not be lost to the idle return
                if (drv.at_speed && next_state == spch_pkg::ST_SPINUP) begin
                    next_state      = spch_pkg::ST_IDLE;
                    next_media_wait = 1'b0;
                    next_remain     = timeout_s(tmo_count);
                    next_presc      = 32'h0;
                    ev[`SPCH_IRQ_MEDIA] = 1'b1;
                end
            end
            default: begin
                next_state = spch_pkg::ST_IDLE;
            end
        endcase

        // Media request seen outside idle and spin-up is held for the spin-up
        if (acc_wr && pwdata[0] && state != spch_pkg::ST_IDLE &&
            state != spch_pkg::ST_SPINUP) begin
            next_media_wait = 1'b1;
        end

        // RULE11: an access-register write or accepted command in idle that stays in idle reloads the interval
        if ((acc_wr || accepted) && state == spch_pkg::ST_IDLE &&
            next_state == spch_pkg::ST_IDLE) begin
            next_remain = timeout_s(tmo_count);
            next_presc  = 32'h0;
        end
        if (accepted && is_timed) begin
            next_remain = timeout_s(cnt);
            next_presc  = 32'h0;
        end

        if (wr_acc && paddr == `SPCH_OFF_INTMASK) begin
            next_int_mask = pwdata[2:0];
        end
        // Set beats the write-one clear
        next_int_stat = int_stat | ev;
        if (wr_acc && paddr == `SPCH_OFF_INTSTAT) begin
            next_int_stat = (int_stat & ~pwdata[2:0]) | ev;
        end

        if (rd_setup) begin
            case (paddr)
                `SPCH_OFF_CMD:     next_prdata = {24'h0, last_cmd};
                `SPCH_OFF_STATUS:  next_prdata = {12'h0, media_wait,
                                                  state, ata_error,
                                                  ata_status};
                `SPCH_OFF_TIMER:   next_prdata = {8'h0, remain,
                                                  tmo_count};
                `SPCH_OFF_INTSTAT: next_prdata = {29'h0, int_stat};
                `SPCH_OFF_INTMASK: next_prdata = {29'h0, int_mask};
                default:           next_prdata = 32'h0;
            endcase
        end
    end

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= spch_pkg::ST_IDLE;
            ata_status <= '{rdy: 1'b1, dsc: 1'b1, default: 1'b0};
            ata_error  <= 8'h00;
            last_cmd   <= 8'h00;
            tmo_count  <= `SPCH_RST_COUNT;
            remain     <= 16'h0000;
            presc      <= 32'h0;
            cmd_busy   <= 1'b0;
            auto_run   <= 1'b0;
            media_wait <= 1'b0;
            int_stat   <= 3'h0;
            int_mask   <= `SPCH_RST_MASK;
            prdata     <= 32'h0;
        end else begin
            state      <= next_state;
            ata_status <= next_ata_status;
            ata_error  <= next_ata_error;
            last_cmd   <= next_last_cmd;
            tmo_count  <= next_tmo_count;
            remain     <= next_remain;
            presc      <= next_presc;
            cmd_busy   <= next_cmd_busy;
            auto_run   <= next_auto_run;
            media_wait <= next_media_wait;
            int_stat   <= next_int_stat;
            int_mask   <= next_int_mask;
            prdata     <= next_prdata;
        end
    end

endmodule

`default_nettype wire

// File: spch_map.svh
// Register map, field positions and timing counts for the standby handler
//------------------------------------------------------------------
// Function
//------------------------------------------------------------------
// Function
// RULE1: Timed standby opcodes: standby now, load timer
// RULE2: Flush write cache before spin-down, bus live
// RULE3: Already spun down: skip the spin-down
// RULE4: Accept commands; media access waits for speed
// RULE5: Timer counts only in idle mode
// RULE6: Count zero disables timer, nonzero enables
// RULE7: Counts 1-240 give count times five
// RULE8: Counts 241-251 give (count-240)*30 minutes
// RULE9: 252=21min, 253=8h, 255=21m15s, 254 reserved
// RULE10: Timer expiry without access enters standby
// RULE11: Host access reloads the full interval
// RULE12: Immediate opcodes: enter standby at once
// RULE13: Immediate standby keeps the stored timer setting
// RULE14: Completion: only abort error; fixed status bits
`ifndef SPCH_MAP_SVH
`define SPCH_MAP_SVH

// Byte offsets on APB
`define SPCH_OFF_CMD      8'h00
`define SPCH_OFF_STATUS   8'h04
`define SPCH_OFF_TIMER    8'h08
`define SPCH_OFF_ACCESS   8'h0C
`define SPCH_OFF_INTSTAT  8'h10
`define SPCH_OFF_INTMASK  8'h14

// Opcodes
`define SPCH_OP_STBY_A    8'hE2
`define SPCH_OP_STBY_B    8'h96
`define SPCH_OP_STBYI_A   8'hE0
`define SPCH_OP_STBYI_B   8'h94

// Interrupt bit positions
`define SPCH_IRQ_DONE     0
`define SPCH_IRQ_AUTO     1
`define SPCH_IRQ_MEDIA    2

// Reset values
`define SPCH_RST_MASK     3'h0
`define SPCH_RST_COUNT    8'h00

// Timing
`define SPCH_CLK_HZ       100000000
`define SPCH_TICK_S       1
`define SPCH_STEP_S       16'h0005
`define SPCH_HALFHOUR_S   16'h0708
`define SPCH_C252_S       16'h04EC
`define SPCH_C253_S       16'h7080
`define SPCH_C255_S       16'h04FB

`endif

// File: spch_pkg.sv
// Types shared by the standby power command handler
package spch_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FLUSH,
        ST_SPINDOWN,
        ST_STANDBY,
        ST_SPINUP
    } spch_state_e;

    typedef struct packed {
        logic bsy;
        logic rdy;
        logic df;
        logic dsc;
        logic drq;
        logic cor;
        logic idx;
        logic err;
    } spch_status_s;

    typedef struct packed {
        logic cache_clean;
        logic spun_down;
        logic at_speed;
    } spch_drive_s;

endpackage

// File: spch_asserts.sv
// Port-level checks for the standby command handler
`timescale 1ns/1ns
`default_nettype none

module spch_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus and drive
    input wire logic pready,
    input wire logic cache_clean,
    input wire logic spun_down,
    input wire logic at_speed,
    input wire logic flush_req,
    input wire logic spin_down_req,
    input wire logic spin_up_req,
    input wire logic media_ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_spin_start;
        !spin_down_req ##1 spin_down_req;
    endsequence
    sequence s_up_done;
        $rose(at_speed) && spin_up_req;
    endsequence

    a_flush_first: assert property (s_spin_start |-> $past(flush_req))
        else $error("spin-down began without a flush");
    a_clean_first: assert property (spin_down_req |-> cache_clean)
        else $error("spin-down with dirty cache");
    a_skip_spin: assert property (
        s_spin_start |-> !(spun_down && $past(spun_down, 4)))
        else $error("spin-down on a stopped spindle");
    a_one_req: assert property (
        $onehot0({flush_req, spin_down_req, spin_up_req}))
        else $error("two drive requests at once");
    a_bus_live: assert property (pready)
        else $error("bus stalled");
    a_flush_ends: assert property (
        $rose(cache_clean) && flush_req |-> ##[1:4] !flush_req)
        else $error("flush request stuck");
    a_down_ends: assert property (
        $rose(spun_down) && spin_down_req |-> ##[1:4] !spin_down_req)
        else $error("spin-down request stuck");
    a_up_ends: assert property (s_up_done |-> ##[1:4] !spin_up_req)
        else $error("spin-up request stuck");
    a_media_speed: assert property (
        media_ready |-> at_speed && !spin_up_req)
        else $error("media ready off speed");
endmodule

bind spch_top spch_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .pready(pready),
    .cache_clean(cache_clean), .spun_down(spun_down), .at_speed(at_speed),
    .flush_req(flush_req), .spin_down_req(spin_down_req),
    .spin_up_req(spin_up_req), .media_ready(media_ready)
);

`default_nettype wire

// File: spch_drive_model.sv
// Behavioural drive mechanics answering the handler's requests
`timescale 1ns/1ns
`default_nettype none

module spch_drive_model #(
    parameter int DLY = 5
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic flush_req,
    input  wire logic spin_down_req,
    input  wire logic spin_up_req,
    output logic      cache_clean,
    output logic      spun_down,
    output logic      at_speed
);
    int cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            cache_clean <= 1'b0;
            spun_down <= 1'b0;
            at_speed <= 1'b1;
        end else if (flush_req || spin_down_req || spin_up_req) begin
            cnt <= (cnt == DLY) ? 0 : cnt + 1;
            if (cnt == DLY) begin
                if (flush_req)
                    cache_clean <= 1'b1;
                if (spin_down_req) begin
                    spun_down <= 1'b1;
                    at_speed <= 1'b0;
                end
                // speed back; new writes dirty the cache
                if (spin_up_req) begin
                    spun_down <= 1'b0;
                    at_speed <= 1'b1;
                    cache_clean <= 1'b0;
                end
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule

`default_nettype wire

// File: spch_bench.sv
// Self-checking bench for the standby command handler
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("mismatch at %0t: got %0h want %0h", $time, g, e); \
    end \
end

module spch_bench;
    localparam int SEC = 1000;
    logic        pclk, presetn, psel, penable, pwrite, last_err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, cache_clean, spun_down, at_speed, irq;
    logic        flush_req, spin_down_req, spin_up_req, media_ready;
    int          err_total, n_compared, downs;

    spch_top #(.SEC_CYCLES(SEC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cache_clean(cache_clean),
        .spun_down(spun_down), .at_speed(at_speed), .flush_req(flush_req),
        .spin_down_req(spin_down_req), .spin_up_req(spin_up_req),
        .media_ready(media_ready), .irq(irq));
    spch_drive_model drive (
        .pclk(pclk), .presetn(presetn), .flush_req(flush_req),
        .spin_down_req(spin_down_req), .spin_up_req(spin_up_req),
        .cache_clean(cache_clean), .spun_down(spun_down),
        .at_speed(at_speed));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) if (spin_down_req) downs++;

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Entered just after a rising edge; holds the request through pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            err_total++;
            $display("mismatch at %0t: bus answer timed out", $time);
            stop_test();
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h04, 32'h0);
            n++;
        end while ((rd[18:16] !== s || rd[7] !== 1'b0) && n < 3000);
        if (n == 3000) begin
            err_total++;
            $display("mismatch at %0t: state wait timed out", $time);
            stop_test();
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] c);
        apb(1'b1, 8'h00, {16'h0, c, op});
        wait_state(3'd3);
        `CHK(rd[15:0], 16'h0050)
    endtask

    task automatic wake();
        apb(1'b1, 8'h0C, 32'h1);
        wait_state(3'd0);
        `CHK(media_ready, 1'b1)
    endtask

    function automatic logic [15:0] exp_sec(input logic [7:0] c);
        if (c <= 8'd240) return 16'(c) * 16'd5;
        if (c <= 8'd251) return 16'(c - 8'd240) * 16'd1800;
        if (c == 8'd252) return 16'd1260;
        if (c == 8'd253) return 16'd28800;
        if (c == 8'd255) return 16'd1275;
        return 16'h0000;
    endfunction

    task automatic t_reset();
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd[15:0], 16'h0050)
        apb(1'b0, 8'h14, 32'h0);
        `CHK(rd[2:0], 3'h0)
        apb(1'b0, 8'h20, 32'h0);
        `CHK({last_err, rd}, {1'b1, 32'h0})
        apb(1'b1, 8'h00, 32'h0000003C);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd[15:0], 16'h0451)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd[7:0], 8'h3C)
        apb(1'b1, 8'h14, 32'h7);
        $display("reset test done");
    endtask

    task automatic t_timed();
        logic [7:0] c [8] = '{8'd1, 8'd240, 8'd241, 8'd251,
                              8'd252, 8'd253, 8'd254, 8'd255};
        for (int i = 0; i < 8; i++) begin
            cmd(i[0] ? 8'h96 : 8'hE2, c[i]);
            if (i == 0) begin
                `CHK(irq, 1'b1)
                apb(1'b1, 8'h10, 32'h7);
                `CHK(irq, 1'b0)
            end
            apb(1'b0, 8'h08, 32'h0);
            `CHK(rd[7:0], c[i])
            wake();
            apb(1'b0, 8'h08, 32'h0);
            `CHK(rd[23:8], exp_sec(c[i]))
        end
        $display("timed standby test done");
    endtask

    task automatic t_imm();
        int d0;
        cmd(8'hE0, 8'h07);
        d0 = downs;
        cmd(8'h94, 8'h07);
        `CHK(downs, d0)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd[7:0], 8'd255)
        wake();
        $display("immediate standby test done");
    endtask

    task automatic t_auto();
        cmd(8'hE2, 8'h00);
        wake();
        repeat (3 * SEC) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd[18:16], 3'd0)
        cmd(8'hE2, 8'h01);
        wake();
        for (int i = 0; i < 3; i++) begin
            repeat (3 * SEC) @(posedge pclk);
            apb(1'b1, 8'h0C, 32'h0);
        end
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd[18:16], 3'd0)
        apb(1'b1, 8'h10, 32'h7);
        repeat (4 * SEC) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd[18:16], 3'd0)
        wait_state(3'd3);
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd[1], 1'b1)
        apb(1'b1, 8'h14, 32'h0);
        `CHK(irq, 1'b0)
        $display("auto standby test done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_timed();
        t_imm();
        t_auto();
        stop_test();
    end
endmodule

`default_nettype wire
